// ---- design/tmr_pin_if.sv ----
`timescale 1ns/1ps
// synchronised pin level and its falling-edge pulse
interface tmr_pin_if;
  logic level;
  logic fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface : tmr_pin_if

// ---- design/tmr_pin_sync.sv ----
`timescale 1ns/1ps
module tmr_pin_sync
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // asynchronous pin
  input wire logic pin_i,
  // synchronised result
  tmr_pin_if.src sync_o
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // two-flop synchroniser, then one stage for edge detection
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // one pulse per falling edge
  assign sync_o.level = sync_q;
  assign sync_o.fall = last_q & ~sync_q;

endmodule : tmr_pin_sync

// ---- design/tmr_pkg.sv ----
package tmr_pkg;

  // register indices on the plain register port
  localparam logic [1:0] TMR_MODE_ADDR = 2'h0;
  localparam logic [1:0] TMR_CTRL_ADDR = 2'h1;
  localparam logic [1:0] TMR_CNT_LO_ADDR = 2'h2;
  localparam logic [1:0] TMR_CNT_HI_ADDR = 2'h3;

  // timer mode register fields, upper nibble is this timer
  localparam int TMR_MODE_GATE_BIT = 7;
  localparam int TMR_MODE_CT_BIT = 6;
  localparam int TMR_MODE_HI_BIT = 5;
  localparam int TMR_MODE_LO_BIT = 4;
  localparam int TMR_MODE_T0_HI_BIT = 1;
  localparam int TMR_MODE_T0_LO_BIT = 0;

  // timer control register fields owned by this timer
  localparam int TMR_CTRL_OVF_BIT = 7;
  localparam int TMR_CTRL_RUN_BIT = 6;
  localparam int TMR_CTRL_IRQF_BIT = 3;
  localparam int TMR_CTRL_TYPE_BIT = 2;

  // reset values
  localparam logic [7:0] TMR_MODE_RST = 8'h00;
  localparam logic [7:0] TMR_CTRL_RST = 8'h00;
  localparam logic [7:0] TMR_CNT_RST = 8'h00;

  // internal timing clock is the peripheral clock divided by six
  localparam int TMR_TICK_DIV = 6;
  localparam logic [2:0] TMR_TICK_LAST = 3'(TMR_TICK_DIV - 1);

  // mode 0 prescaler wraps at 32
  localparam logic [4:0] TMR_PRESC_MAX = 5'h1f;
  localparam logic [7:0] TMR_BYTE_MAX = 8'hff;

  // operating modes from the two mode-select bits
  typedef enum logic [1:0] {
    TMR_MODE_13BIT,
    TMR_MODE_16BIT,
    TMR_MODE_RELOAD,
    TMR_MODE_HALT
  } tmr_mode_e;

endpackage : tmr_pkg

// ---- design/tmr_timer1.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - mode 0 is a 13-bit count, five low bits of the low byte prescale by 32 into the high byte, upper three low bits kept.
// - mode 1 cascades low and high bytes into one 16-bit counter.
// - mode 2 counts the low byte only and on overflow sets the flag and reloads it from the unchanged high byte.
// - mode 3 halts the count and holds its value.
// - gate, timer-or-counter select and the mode bits sit in the upper nibble of the mode register.
// - overflow flag, run bit, external flag and type bit sit at bits 7, 6, 3 and 2 of the control register.
// - with the gate bit clear the count advances only while the run bit is set or timer 0 is in mode 3.
// - with gate and run both set the external interrupt 1 pin level decides whether counting proceeds.
// - a wrap from all ones to all zeros sets the overflow flag and requests an interrupt.
// - the count source is the internal timing tick or external events, chosen by the select bit.
// - when timer 0 is in mode 3 it owns the overflow flag and run bit of this timer.
// - every overflow of this timer is offered to the serial port as a baud tick.
module tmr_timer1
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // pins
  input wire logic count_event_pin_i,
  input wire logic external_irq1_pin_i,
  // timer 0 side
  input wire logic t0_high_ovf_i,
  output logic [3:0] t0_mode_o,
  output logic t0_run_bit_o,
  // core interrupt side
  input wire logic ovf_ack_i,
  input wire logic ext1_ack_i,
  output logic ovf_irq_o,
  output logic ext1_irq_o,
  // serial port baud source
  output logic baud_tick_o
);

  // register state
  logic [7:0] timer_mode_reg_q;
  logic overflow_flag_q;
  logic run_bit_q;
  logic external_irq1_flag_q;
  logic external_irq1_type_q;
  logic [7:0] count_low_byte_q;
  logic [7:0] count_high_byte_q;
  logic [7:0] rdata_q;
  logic baud_tick_q;

  // divider state
  logic [2:0] tick_cnt_q;
  logic tick_en;

  // decoded fields
  logic pin_gate_bit;
  logic counter_timer_select;
  logic mode_select_hi;
  logic mode_select_lo;
  tmr_mode_e mode;
  logic t0_in_mode3;

  // counting terms
  logic src_pulse;
  logic run_eff;
  logic gate_ok;
  logic count_en;
  logic wrap;
  logic [7:0] count_low_byte_d;
  logic [7:0] count_high_byte_d;

  // write strobes per register
  logic wr_mode;
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;

  // synchronised pins
  tmr_pin_if evt_pin ();
  tmr_pin_if irq_pin ();

  // external count pin
  tmr_pin_sync u_evt_sync (
    .clk_i (clk_i),
    .srst_i (srst_i),
    .pin_i (count_event_pin_i),
    .sync_o (evt_pin.src)
  );

  // external interrupt 1 pin
  tmr_pin_sync u_irq_sync (
    .clk_i (clk_i),
    .srst_i (srst_i),
    .pin_i (external_irq1_pin_i),
    .sync_o (irq_pin.src)
  );

  // field decode from the upper nibble of the mode register
  assign pin_gate_bit = timer_mode_reg_q[TMR_MODE_GATE_BIT];
  assign counter_timer_select = timer_mode_reg_q[TMR_MODE_CT_BIT];
  assign mode_select_hi = timer_mode_reg_q[TMR_MODE_HI_BIT];
  assign mode_select_lo = timer_mode_reg_q[TMR_MODE_LO_BIT];
  assign mode = tmr_mode_e'({mode_select_hi, mode_select_lo});

  // timer 0 mode 3 detection from the lower nibble
  assign t0_in_mode3 = timer_mode_reg_q[TMR_MODE_T0_HI_BIT] &
                       timer_mode_reg_q[TMR_MODE_T0_LO_BIT];

  // register write decode
  always_comb begin
    wr_mode = 1'b0;
    wr_ctrl = 1'b0;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    if (reg_we_i && reg_addr_i == TMR_MODE_ADDR) begin
      wr_mode = 1'b1;
    end else if (reg_we_i && reg_addr_i == TMR_CTRL_ADDR) begin
      wr_ctrl = 1'b1;
    end else if (reg_we_i && reg_addr_i == TMR_CNT_LO_ADDR) begin
      wr_lo = 1'b1;
    end else if (reg_we_i && reg_addr_i == TMR_CNT_HI_ADDR) begin
      wr_hi = 1'b1;
    end
  end

  // divide-by-six internal timing tick
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tick_cnt_q <= 3'h0;
    end else if (tick_cnt_q == TMR_TICK_LAST) begin
      tick_cnt_q <= 3'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 3'h1;
    end
  end

  assign tick_en = (tick_cnt_q == TMR_TICK_LAST);

  // count source: timing tick or external falling edge
  assign src_pulse = counter_timer_select ? evt_pin.fall : tick_en;

  // timer 0 in mode 3 takes the run bit, so this one runs free
  assign run_eff = t0_in_mode3 ? 1'b1 : run_bit_q;

  // gate: pin high lets counting proceed
  assign gate_ok = ~pin_gate_bit | irq_pin.level;

  // overall increment enable, halted in mode 3
  assign count_en = src_pulse & run_eff & gate_ok &
                    (mode != TMR_MODE_HALT);

  // next count and wrap per mode
  always_comb begin
    count_low_byte_d = count_low_byte_q;
    count_high_byte_d = count_high_byte_q;
    wrap = 1'b0;
    case (mode)
      TMR_MODE_13BIT: begin
        count_low_byte_d[4:0] = count_low_byte_q[4:0] + 5'h01;
        if (count_low_byte_q[4:0] == TMR_PRESC_MAX) begin
          count_high_byte_d = count_high_byte_q + 8'h01;
          wrap = (count_high_byte_q == TMR_BYTE_MAX);
        end
      end
      TMR_MODE_16BIT: begin
        count_low_byte_d = count_low_byte_q + 8'h01;
        if (count_low_byte_q == TMR_BYTE_MAX) begin
          count_high_byte_d = count_high_byte_q + 8'h01;
          wrap = (count_high_byte_q == TMR_BYTE_MAX);
        end
      end
      TMR_MODE_RELOAD: begin
        if (count_low_byte_q == TMR_BYTE_MAX) begin
          count_low_byte_d = count_high_byte_q;
          wrap = 1'b1;
        end else begin
          count_low_byte_d = count_low_byte_q + 8'h01;
        end
      end
      default: begin
        wrap = 1'b0;
      end
    endcase
  end

  // mode register, both nibbles
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      timer_mode_reg_q <= TMR_MODE_RST;
    end else if (wr_mode) begin
      timer_mode_reg_q <= reg_wdata_i;
    end
  end

  // low count byte, software write beats counting
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_low_byte_q <= TMR_CNT_RST;
    end else if (wr_lo) begin
      count_low_byte_q <= reg_wdata_i;
    end else if (count_en) begin
      count_low_byte_q <= count_low_byte_d;
    end
  end

  // high count byte, never touched by the reload
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      count_high_byte_q <= TMR_CNT_RST;
    end else if (wr_hi) begin
      count_high_byte_q <= reg_wdata_i;
    end else if (count_en) begin
      count_high_byte_q <= count_high_byte_d;
    end
  end

  // run bit and type bit, software owned
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      run_bit_q <= TMR_CTRL_RST[TMR_CTRL_RUN_BIT];
      external_irq1_type_q <= TMR_CTRL_RST[TMR_CTRL_TYPE_BIT];
    end else if (wr_ctrl) begin
      run_bit_q <= reg_wdata_i[TMR_CTRL_RUN_BIT];
      external_irq1_type_q <= reg_wdata_i[TMR_CTRL_TYPE_BIT];
    end
  end

  // overflow flag: own wrap, or timer 0 high overflow in its mode 3
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      overflow_flag_q <= TMR_CTRL_RST[TMR_CTRL_OVF_BIT];
    end else if (t0_in_mode3 ? t0_high_ovf_i : (count_en & wrap)) begin
      overflow_flag_q <= 1'b1;
    end else if (wr_ctrl) begin
      overflow_flag_q <= reg_wdata_i[TMR_CTRL_OVF_BIT];
    end else if (ovf_ack_i) begin
      overflow_flag_q <= 1'b0;
    end
  end

  // external interrupt 1 flag: edge latched or level followed
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      external_irq1_flag_q <= TMR_CTRL_RST[TMR_CTRL_IRQF_BIT];
    end else if (!external_irq1_type_q) begin
      external_irq1_flag_q <= ~irq_pin.level;
    end else if (irq_pin.fall) begin
      external_irq1_flag_q <= 1'b1;
    end else if (wr_ctrl) begin
      external_irq1_flag_q <= reg_wdata_i[TMR_CTRL_IRQF_BIT];
    end else if (ext1_ack_i) begin
      external_irq1_flag_q <= 1'b0;
    end
  end

  // baud tick on every own overflow, flag ownership aside
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      baud_tick_q <= 1'b0;
    end else begin
      baud_tick_q <= count_en & wrap;
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_q <= 8'h00;
    end else if (!reg_re_i) begin
      rdata_q <= 8'h00;
    end else if (reg_addr_i == TMR_MODE_ADDR) begin
      rdata_q <= timer_mode_reg_q;
    end else if (reg_addr_i == TMR_CTRL_ADDR) begin
      rdata_q <= {overflow_flag_q, run_bit_q, 2'b00,
                  external_irq1_flag_q, external_irq1_type_q, 2'b00};
    end else if (reg_addr_i == TMR_CNT_LO_ADDR) begin
      rdata_q <= count_low_byte_q;
    end else begin
      rdata_q <= count_high_byte_q;
    end
  end

  // outputs
  assign reg_rdata_o = rdata_q;
  assign t0_mode_o = timer_mode_reg_q[3:0];
  assign t0_run_bit_o = run_bit_q;
  assign ovf_irq_o = overflow_flag_q & ~t0_in_mode3;
  assign ext1_irq_o = external_irq1_flag_q;
  assign baud_tick_o = baud_tick_q;

endmodule : tmr_timer1

// ---- dv/tmr_core_model.sv ----
`timescale 1ns/1ps
// core side: acks interrupts, counts baud ticks
module tmr_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // behaviour controls
  input wire logic ack_en_i,
  input wire logic slow_i,
  // from the timer
  input wire logic ovf_irq_i,
  input wire logic ext_irq_i,
  input wire logic baud_i,
  // acks to the timer, baud count to the bench
  output logic ovf_ack_o,
  output logic ext_ack_o,
  output int baud_cnt_o
);
  logic [2:0] wait_q;
  // wait counter while the overflow request is pending
  always_ff @(posedge clk_i) begin
    if (srst_i || !ovf_irq_i) wait_q <= 3'h0;
    else if (wait_q != 3'h7) wait_q <= wait_q + 3'h1;
  end
  // vector acks, prompt or slow
  always_ff @(posedge clk_i) begin
    ovf_ack_o <= !srst_i && ack_en_i && ovf_irq_i && !ovf_ack_o
      && (!slow_i || wait_q == 3'h4);
    ext_ack_o <= !srst_i && ack_en_i && ext_irq_i && !ext_ack_o;
  end
  // serial side takes each overflow as a baud tick
  always_ff @(posedge clk_i) begin
    if (srst_i) baud_cnt_o <= 0;
    else baud_cnt_o <= baud_cnt_o + int'(baud_i);
  end
endmodule : tmr_core_model

// ---- dv/tmr_timer1_assertions.sv ----
`timescale 1ns/1ps
module tmr_timer1_assertions
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  // outputs under watch
  input wire logic [3:0] t0_mode_o,
  input wire logic t0_run_bit_o,
  input wire logic ovf_irq_o,
  input wire logic baud_tick_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // shadow of the mode register, kept from writes
  logic [7:0] mode_q;
  logic t0_own;
  always_ff @(posedge clk_i) begin
    if (srst_i) mode_q <= TMR_MODE_RST;
    else if (reg_we_i && reg_addr_i == TMR_MODE_ADDR) mode_q <= reg_wdata_i;
  end
  // timer 0 in mode 3 takes flag and run bit
  assign t0_own = t0_mode_o[1:0] == 2'h3;
  sequence s_wr(a); reg_we_i && reg_addr_i == a; endsequence
  sequence s_rd(a); reg_re_i && reg_addr_i == a; endsequence
  property p_ctrl_zero;
    s_rd(TMR_CTRL_ADDR) |=> reg_rdata_o[5:4] == 2'h0 && reg_rdata_o[1:0] == 2'h0;
  endproperty
  property p_mode_rd;
    s_rd(TMR_MODE_ADDR) |=> reg_rdata_o == $past(mode_q);
  endproperty
  property p_t0_mode;
    s_wr(TMR_MODE_ADDR) |=> t0_mode_o == $past(reg_wdata_i[3:0]);
  endproperty
  property p_run;
    s_wr(TMR_CTRL_ADDR) |=> t0_run_bit_o == $past(reg_wdata_i[TMR_CTRL_RUN_BIT]);
  endproperty
  property p_mask; t0_own |-> !ovf_irq_o; endproperty
  property p_baud_flag;
    baud_tick_o && !$past(t0_own) |-> ovf_irq_o;
  endproperty
  property p_baud_pulse; baud_tick_o |=> !baud_tick_o; endproperty
  property p_hold;
    $past(!t0_run_bit_o && !t0_own) |-> !baud_tick_o;
  endproperty
  property p_halt; $past(mode_q[5:4] == 2'h3) |-> !baud_tick_o; endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("ctrl spare");
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback");
  a_t0_mode: assert property (p_t0_mode) else $error("t0 mode out");
  a_run: assert property (p_run) else $error("run bit out");
  a_mask: assert property (p_mask) else $error("irq not masked");
  a_baud_flag: assert property (p_baud_flag) else $error("tick no flag");
  a_baud_pulse: assert property (p_baud_pulse) else $error("tick long");
  a_hold: assert property (p_hold) else $error("count while off");
  a_halt: assert property (p_halt) else $error("count in halt");
endmodule : tmr_timer1_assertions

bind tmr_timer1 tmr_timer1_assertions u_chk (
  .clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
  .reg_rdata_o, .t0_mode_o, .t0_run_bit_o, .ovf_irq_o, .baud_tick_o
);

// ---- dv/tmr_timer1_tb_top.sv ----
`timescale 1ns/1ps
module tmr_timer1_tb_top;
  import tmr_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0, re = 1'b0, cnt_pin = 1'b1, irq_pin = 1'b1;
  logic t0_ovf = 1'b0, ack_en = 1'b0, slow = 1'b0;
  logic [7:0] rdata;
  logic [3:0] t0_mode;
  logic t0_run, ovf_ack, ext_ack, ovf_irq, ext_irq, baud;
  int baud_cnt;
  int bad_count = 0;
  int n_compared = 0;
  // design and core-side partner
  tmr_timer1 u_dut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
    .count_event_pin_i(cnt_pin), .external_irq1_pin_i(irq_pin),
    .t0_high_ovf_i(t0_ovf), .t0_mode_o(t0_mode), .t0_run_bit_o(t0_run),
    .ovf_ack_i(ovf_ack), .ext1_ack_i(ext_ack), .ovf_irq_o(ovf_irq),
    .ext1_irq_o(ext_irq), .baud_tick_o(baud));
  tmr_core_model u_core (.clk_i(clk_i), .srst_i(srst_i), .ack_en_i(ack_en),
    .slow_i(slow), .ovf_irq_i(ovf_irq), .ext_irq_i(ext_irq), .baud_i(baud),
    .ovf_ack_o(ovf_ack), .ext_ack_o(ext_ack), .baud_cnt_o(baud_cnt));
  // clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    we <= 1'b0;
  endtask : wr
  task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp
  task automatic chk_rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    re <= 1'b1;
    addr <= a;
    @(posedge clk_i);
    re <= 1'b0;
    #1;
    cmp(exp, rdata);
  endtask : chk_rd
  // stop first, then load counts, mode and control
  task automatic setup(input logic [7:0] m, lo, hi, c);
    wr(TMR_CTRL_ADDR, 8'h00);
    wr(TMR_CNT_LO_ADDR, lo);
    wr(TMR_CNT_HI_ADDR, hi);
    wr(TMR_MODE_ADDR, m);
    wr(TMR_CTRL_ADDR, c);
  endtask : setup
  task automatic fall(input int n);
    repeat (n) begin
      @(posedge clk_i);
      cnt_pin <= 1'b0;
      repeat (4) @(posedge clk_i);
      cnt_pin <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
  endtask : fall
  task automatic wait_baud;
    int i;
    for (i = 0; i < 20; i++) begin
      @(negedge clk_i);
      if (baud === 1'b1) break;
    end
    cmp(8'h01, {7'h00, i < 20});
  endtask : wait_baud
  task automatic t_reset;
    for (int a = 0; a < 4; a++) chk_rd(2'(a), 8'h00);
  endtask : t_reset
  task automatic t_reload;
    setup(8'h20, 8'hff, 8'ha0, 8'h40);
    wait_baud();
    wr(TMR_CTRL_ADDR, 8'h80);
    chk_rd(TMR_CNT_LO_ADDR, 8'ha0);
    chk_rd(TMR_CNT_HI_ADDR, 8'ha0);
    chk_rd(TMR_CTRL_ADDR, 8'h80);
    cmp(8'h01, {7'h00, ovf_irq});
    cmp(8'h01, 8'(baud_cnt));
  endtask : t_reload
  task automatic t_count(input logic [7:0] m, lo, hi, n, elo, ehi);
    setup(m, lo, hi, 8'h40);
    fall(n);
    wr(TMR_CTRL_ADDR, 8'h00);
    chk_rd(TMR_CNT_LO_ADDR, elo);
    chk_rd(TMR_CNT_HI_ADDR, ehi);
  endtask : t_count
  task automatic t_gate;
    setup(8'h50, 8'h10, 8'h00, 8'h00);
    fall(1);
    chk_rd(TMR_CNT_LO_ADDR, 8'h10);
    wr(TMR_MODE_ADDR, 8'hd0);
    wr(TMR_CTRL_ADDR, 8'h44);
    irq_pin <= 1'b0;
    fall(1);
    chk_rd(TMR_CNT_LO_ADDR, 8'h10);
    chk_rd(TMR_CTRL_ADDR, 8'h4c);
    irq_pin <= 1'b1;
    fall(1);
    chk_rd(TMR_CNT_LO_ADDR, 8'h11);
    ack_en <= 1'b1;
    repeat (3) @(posedge clk_i);
    cmp(8'h00, {7'h00, ext_irq});
    ack_en <= 1'b0;
  endtask : t_gate
  task automatic t_t0_owns;
    setup(8'h23, 8'hff, 8'hff, 8'h00);
    wait_baud();
    @(posedge clk_i);
    t0_ovf <= 1'b1;
    @(posedge clk_i);
    t0_ovf <= 1'b0;
    cmp(8'h00, {7'h00, ovf_irq});
    chk_rd(TMR_CTRL_ADDR, 8'h80);
    ack_en <= 1'b1;
    slow <= 1'b1;
    wr(TMR_MODE_ADDR, 8'h20);
    #1;
    cmp(8'h01, {7'h00, ovf_irq});
    repeat (12) @(posedge clk_i);
    cmp(8'h00, {7'h00, ovf_irq});
  endtask : t_t0_owns
  task automatic complete_run;
    $display("compared=%0d errors=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_reload();
    t_count(8'h50, 8'hff, 8'h12, 1, 8'h00, 8'h13);
    t_count(8'h40, 8'hff, 8'h05, 1, 8'he0, 8'h06);
    t_count(8'h70, 8'h33, 8'h44, 2, 8'h33, 8'h44);
    t_gate();
    t_t0_owns();
    complete_run();
  end
  // watchdog
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
endmodule : tmr_timer1_tb_top
